// [verilog/twelve_bit_interval_timer.sv]
// Twelve-bit interval timer with its clock gate, clock select and control register.
// Assumes the slow oscillator arrives as a level synchronous to clk and much slower than it.
`timescale 1ns/1ns
`default_nettype none
module twelve_bit_interval_timer
  import itimer_pkg::*;
(
  input wire logic clk, // System clock, 20 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire sfr_req_type req, // Register access request.
  input wire logic slow_osc, // Low-speed oscillator level.
  output logic [DATA_W-1:0] rdata, // Read data, valid with rvalid.
  output logic rvalid, // One-cycle read answer.
  output logic interval_interrupt_request // One-cycle interval interrupt pulse.
);
  logic [7:0] peripheral_clock_gate_ff;
  logic [7:0] operation_clock_select_ff;
  logic run_wr_ff;
  logic run_ff;
  logic [CNT_W-1:0] compare_value_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic osc_prev_ff;
  logic irq_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic rvalid_ff;
  logic gate_on;
  logic tick;
  logic match;
  logic ctrl_wr;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] period_ff;
  logic seen_ff;

  // Clock gate and the enable that holds the timer in reset.
  assign gate_on = peripheral_clock_gate_ff[GATE_EN_BIT];
  assign ctrl_wr = req.wr && req.word && gate_on && (req.addr == CTRL_ADDR);
  assign match = (cnt_ff == compare_value_ff);

  // Count clock ticks only while the slow oscillator is selected.
  assign tick = slow_osc && !osc_prev_ff && operation_clock_select_ff[SRC_BIT];

  // Next counter value wraps to zero on the compare match.
  assign nxt_cnt = match ? CNT_ZERO : cnt_ff + CNT_ONE;

  // Clock gate register; only implemented bits are stored.
  always_ff @(posedge clk) begin
    if (srst) begin
      peripheral_clock_gate_ff <= GATE_RST;
    end else if (req.wr && req.addr == GATE_ADDR) begin
      peripheral_clock_gate_ff <= req.wdata[7:0] & GATE_MASK;
    end
  end

  // Clock select register stays writable with the gate off.
  always_ff @(posedge clk) begin
    if (srst) begin
      operation_clock_select_ff <= CLKSEL_RST;
    end else if (req.wr && req.addr == CLKSEL_ADDR) begin
      operation_clock_select_ff <= req.wdata[7:0] & CLKSEL_MASK;
    end
  end

  // Edge detector on the slow oscillator level.
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_prev_ff <= 1'h0;
    end else begin
      osc_prev_ff <= slow_osc;
    end
  end

  // Written run request and compare value; a compare in a toggling write is kept too.
  always_ff @(posedge clk) begin
    if (srst || !gate_on) begin
      run_wr_ff <= RUN_RST;
      compare_value_ff <= CMP_RST;
    end else if (ctrl_wr) begin
      run_wr_ff <= req.wdata[RUN_BIT];
      compare_value_ff <= req.wdata[CNT_W-1:0];
    end
  end

  // The run request takes effect on the next count clock edge.
  always_ff @(posedge clk) begin
    if (srst || !gate_on) begin
      run_ff <= RUN_RST;
    end else if (tick) begin
      run_ff <= run_wr_ff;
    end
  end

  // Counter is cleared while stopped, so a restart counts from zero.
  always_ff @(posedge clk) begin
    if (srst || !gate_on || !run_ff) begin
      cnt_ff <= CNT_ZERO;
    end else if (tick) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Interrupt pulse lasts one system clock per match.
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_ff <= 1'h0;
    end else begin
      irq_ff <= gate_on && run_ff && tick && match;
    end
  end

  // Read port; the run bit shows the applied state, not the written one.
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= '0;
      rvalid_ff <= 1'h0;
    end else begin
      rvalid_ff <= req.rd;
      if (req.rd) begin
        unique case (req.addr)
          GATE_ADDR: rdata_ff <= {8'h00, peripheral_clock_gate_ff};
          CLKSEL_ADDR: rdata_ff <= {8'h00, operation_clock_select_ff};
          CTRL_ADDR: begin
            // A gated-off timer reads back its reset value, even in the cycle the gate drops.
            if (gate_on) begin
              rdata_ff <= {run_ff, 3'h0, compare_value_ff};
            end else begin
              rdata_ff <= {RUN_RST, 3'h0, CMP_RST};
            end
          end
          default: rdata_ff <= '0;
        endcase
      end
    end
  end

  assign rdata = rdata_ff;
  assign rvalid = rvalid_ff;
  assign interval_interrupt_request = irq_ff;

  // Helper for the period check: ticks since the last match while running.
  always_ff @(posedge clk) begin
    if (srst || !gate_on || !run_ff) begin
      period_ff <= CNT_ZERO;
      seen_ff <= 1'h0;
    end else if (tick) begin
      period_ff <= match ? CNT_ZERO : period_ff + CNT_ONE;
      seen_ff <= seen_ff || match;
    end
  end

  gate_off_a: assert property (@(posedge clk) disable iff (srst)
    !gate_on |=> (cnt_ff == CNT_ZERO) && !run_ff && (compare_value_ff == CMP_RST))
    else $error("Timer not held in reset with clock gate off.");

  clock_select_a: assert property (@(posedge clk) disable iff (srst)
    gate_on && !operation_clock_select_ff[SRC_BIT] |=> $stable(run_ff) && $stable(cnt_ff))
    else $error("Count clock ticked without the slow oscillator selected.");

  run_stop_a: assert property (@(posedge clk) disable iff (srst)
    gate_on && tick && !run_wr_ff && !ctrl_wr |=> !run_ff ##1 (cnt_ff == CNT_ZERO))
    else $error("Stop did not halt and clear the counter.");

  period_len_a: assert property (@(posedge clk) disable iff (srst)
    gate_on && run_ff && tick && match && seen_ff |-> period_ff == compare_value_ff)
    else $error("Interrupt period differs from compare value plus one.");

  match_clear_a: assert property (@(posedge clk) disable iff (srst)
    gate_on && run_ff && tick && match |=> (cnt_ff == CNT_ZERO) && irq_ff)
    else $error("Match did not clear counter and raise the interrupt.");

  run_delay_a: assert property (@(posedge clk) disable iff (srst)
    gate_on && !tick && run_ff != run_wr_ff |=> $stable(run_ff))
    else $error("Run bit applied without a count clock edge.");

  run_read_a: assert property (@(posedge clk) disable iff (srst)
    gate_on && req.rd && req.addr == CTRL_ADDR |=> rvalid && rdata[RUN_BIT] == $past(run_ff))
    else $error("Run bit read does not show the applied value.");

  compare_upd_a: assert property (@(posedge clk) disable iff (srst)
    ctrl_wr |=> compare_value_ff == $past(req.wdata[CNT_W-1:0]))
    else $error("Compare value not taken from the control write.");

  start_zero_a: assert property (@(posedge clk) disable iff (srst)
    $rose(run_ff) |-> (cnt_ff == CNT_ZERO) ##1 !irq_ff)
    else $error("Start did not begin from zero.");

  irq_pulse_a: assert property (@(posedge clk) disable iff (srst)
    irq_ff |=> !irq_ff)
    else $error("Interrupt request wider than one clock.");

  // Register port checks while the clock gate is off, and of the clock gate write itself.
  gated_read_a: assert property (@(posedge clk) disable iff (srst)
    !gate_on && req.rd && req.addr == CTRL_ADDR |=> rdata == {RUN_RST, 3'h0, CMP_RST})
    else $error("Control read with the clock gate off did not show defaults.");

  gated_write_a: assert property (@(posedge clk) disable iff (srst)
    !gate_on && req.wr && req.addr == CTRL_ADDR |=> !run_wr_ff && (compare_value_ff == CMP_RST))
    else $error("Control write taken with the clock gate off.");

  select_gated_a: assert property (@(posedge clk) disable iff (srst)
    !gate_on && req.wr && req.addr == CLKSEL_ADDR |=>
      operation_clock_select_ff[SRC_BIT] == $past(req.wdata[SRC_BIT]))
    else $error("Clock select write lost with the clock gate off.");

  gate_write_a: assert property (@(posedge clk) disable iff (srst)
    req.wr && req.addr == GATE_ADDR |=> gate_on == $past(req.wdata[GATE_EN_BIT]))
    else $error("Clock gate bit not taken from the write.");

  // Counter and interrupt checks around the count clock edges.
  count_hold_a: assert property (@(posedge clk) disable iff (srst)
    gate_on && run_ff && !tick |=> $stable(cnt_ff))
    else $error("Counter moved without a count clock edge.");

  count_step_a: assert property (@(posedge clk) disable iff (srst)
    gate_on && run_ff && tick && !match |=> cnt_ff == $past(cnt_ff) + CNT_ONE)
    else $error("Counter did not advance by one on a count clock edge.");

  stop_quiet_a: assert property (@(posedge clk) disable iff (srst)
    !run_ff |=> !irq_ff)
    else $error("Interrupt raised while stopped.");

  tick_only_a: assert property (@(posedge clk) disable iff (srst)
    !tick |=> !irq_ff)
    else $error("Interrupt raised without a count clock edge.");
endmodule
`default_nettype wire

// [common/itimer_pkg.sv]
// Constants, register map and request carrier of the 12-bit interval timer.
// Assumes one 20 MHz system clock and a synchronous, active-high reset.
package itimer_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CNT_W = 12;

  localparam logic [ADDR_W-1:0] GATE_ADDR = 20'hf00f0;
  localparam logic [ADDR_W-1:0] CLKSEL_ADDR = 20'hf00f3;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 20'hfff90;

  localparam logic [7:0] GATE_RST = 8'h00;
  localparam logic [7:0] GATE_MASK = 8'ha5;
  localparam int GATE_EN_BIT = 7;

  localparam logic [7:0] CLKSEL_RST = 8'h00;
  localparam logic [7:0] CLKSEL_MASK = 8'h10;
  localparam int SRC_BIT = 4;

  localparam int RUN_BIT = 15;
  localparam logic RUN_RST = 1'h0;
  localparam logic [CNT_W-1:0] CMP_RST = 12'hfff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  // One register access request, held for one clock.
  typedef struct packed {
    logic wr;
    logic rd;
    logic word;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sfr_req_type;
endpackage

// [verif/twelve_bit_interval_timer_tb_top.sv]
// Self-checking testbench of the twelve-bit interval timer.
// Assumes the timer's ports as declared; the bench drives every input itself.
`timescale 1ns/1ns
`default_nettype none
module twelve_bit_interval_timer_tb_top
  import itimer_pkg::*;
;
  logic clk;
  logic srst;
  logic slow_osc;
  logic irq;
  logic rvalid;
  logic [DATA_W-1:0] rdata;
  sfr_req_type req;
  int num_errors = 0;
  int num_checks = 0;
  int irq_cnt = 0;

  // Device under test.
  twelve_bit_interval_timer twelve_bit_interval_timer_inst (.clk(clk), .srst(srst), .req(req),
    .slow_osc(slow_osc), .rdata(rdata), .rvalid(rvalid), .interval_interrupt_request(irq));

  // The system clock and a counter of interrupt pulses.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (irq === 1'b1) irq_cnt++;

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Compares one value and counts the result.
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register access, the strobe held for exactly one edge.
  task automatic put(input logic wr, input logic rd, input logic wd, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    @(posedge clk);
    #5 req = '{wr: wr, rd: rd, word: wd, addr: a, wdata: d};
    @(posedge clk);
    #5 req = '0;
  endtask

  // Reads a register and checks the answer of the following cycle.
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    put(1'b0, 1'b1, 1'b1, a, 16'h0000);
    check("rvalid", 16'h0001, {15'h0, rvalid});
    check("rdata", exp, rdata);
  endtask

  // Gives n count ticks, each one clock high and three low.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      #5 slow_osc = 1'b1;
      @(posedge clk);
      #5 slow_osc = 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask

  // Starts with one compare value, checks the period, then stops.
  task automatic period_run(input logic [11:0] cmp);
    int base;
    put(1'b1, 1'b0, 1'b1, CTRL_ADDR, {4'h0, cmp});
    ticks(1);
    put(1'b1, 1'b0, 1'b0, CTRL_ADDR, {4'h8, ~cmp});
    rd_chk(CTRL_ADDR, {4'h0, cmp});
    put(1'b1, 1'b0, 1'b1, CTRL_ADDR, {4'h8, cmp});
    rd_chk(CTRL_ADDR, {4'h0, cmp});
    base = irq_cnt;
    ticks(1);
    rd_chk(CTRL_ADDR, {4'h8, cmp});
    ticks(int'(cmp));
    check("irq early", 16'(base), 16'(irq_cnt));
    ticks(1);
    check("irq first", 16'(base + 1), 16'(irq_cnt));
    ticks(int'(cmp) + 1);
    check("irq second", 16'(base + 2), 16'(irq_cnt));
    put(1'b1, 1'b0, 1'b1, CTRL_ADDR, {4'h0, cmp});
    ticks(4);
    check("irq stopped", 16'(base + 2), 16'(irq_cnt));
    rd_chk(CTRL_ADDR, {4'h0, cmp});
  endtask

  // Turns the clock gate off under a running timer.
  task automatic gate_drop();
    int base;
    put(1'b1, 1'b0, 1'b1, CTRL_ADDR, 16'h8001);
    ticks(2);
    put(1'b1, 1'b0, 1'b1, GATE_ADDR, 16'h0000);
    base = irq_cnt;
    put(1'b1, 1'b0, 1'b1, CTRL_ADDR, 16'h8123);
    ticks(6);
    check("irq gated", 16'(base), 16'(irq_cnt));
    rd_chk(CTRL_ADDR, 16'h0fff);
    rd_chk(CLKSEL_ADDR, 16'h0010);
  endtask

  // Asks to run before the slow oscillator is selected, then gates the timer off.
  task automatic sel_missing();
    int base;
    base = irq_cnt;
    put(1'b1, 1'b0, 1'b1, CTRL_ADDR, 16'h8002);
    ticks(3);
    rd_chk(CTRL_ADDR, 16'h0002);
    check("irq unselected", 16'(base), 16'(irq_cnt));
    put(1'b1, 1'b0, 1'b1, GATE_ADDR, 16'h0000);
    rd_chk(CTRL_ADDR, 16'h0fff);
  endtask

  // Reset, register defaults and the gated refusal, then the scenarios.
  initial begin
    srst = 1'b1;
    slow_osc = 1'b0;
    req = '0;
    repeat (16) @(posedge clk);
    #5 srst = 1'b0;
    rd_chk(GATE_ADDR, 16'h0000);
    rd_chk(CLKSEL_ADDR, 16'h0000);
    rd_chk(CTRL_ADDR, 16'h0fff);
    rd_chk(20'hf00f1, 16'h0000);
    put(1'b1, 1'b0, 1'b1, CTRL_ADDR, 16'h8123);
    rd_chk(CTRL_ADDR, 16'h0fff);
    put(1'b1, 1'b0, 1'b1, GATE_ADDR, 16'h0080);
    rd_chk(GATE_ADDR, 16'h0080);
    sel_missing();
    put(1'b1, 1'b0, 1'b1, CLKSEL_ADDR, 16'h0010);
    rd_chk(CLKSEL_ADDR, 16'h0010);
    put(1'b1, 1'b0, 1'b1, GATE_ADDR, 16'h0080);
    rd_chk(GATE_ADDR, 16'h0080);
    rd_chk(CLKSEL_ADDR, 16'h0010);
    period_run(12'h001);
    period_run(12'h003);
    period_run(12'hfff);
    gate_drop();
    print_verdict();
  end
endmodule
`default_nettype wire
